/* clc_cfg.svh */
`ifndef CLC_CFG_SVH
`define CLC_CFG_SVH

// Register byte offsets
`define OFFSET_CONTROL_LOW 8'h00
`define OFFSET_CONTROL_HIGH 8'h04
`define OFFSET_SOURCE_SELECT 8'h08
`define OFFSET_GATE_SELECT_LOW 8'h0c
`define OFFSET_GATE_SELECT_HIGH 8'h10

// Control low field positions
`define CELL_ENABLE_BIT 15
`define RISE_IRQ_ENABLE_BIT 11
`define FALL_IRQ_ENABLE_BIT 10
`define PIN_DRIVE_ENABLE_BIT 7
`define OUTPUT_LEVEL_STATUS_BIT 6
`define OUTPUT_INVERT_BIT 5
`define MODE_MSB 2
`define MODE_LSB 0

// Source select field width and spacing
`define SOURCE_SELECT_WIDTH 3
`define SOURCE_SELECT_STRIDE 4

// Gate enable layout: gate*8 + source*2 + 1 is true, + 0 is inverted
`define GATE_ENABLE_STRIDE 8
`define TRUE_ENABLE_SLOT 1
`define INVERTED_ENABLE_SLOT 0

// Writable bits of each register
`define MASK_CONTROL_LOW 16'h8ca7
`define MASK_CONTROL_HIGH 16'h000f
`define MASK_SOURCE_SELECT 16'h7777
`define MASK_GATE_SELECT 16'hffff

// Reset values
`define RESET_CONTROL_LOW 16'h0000
`define RESET_CONTROL_HIGH 16'h0000
`define RESET_SOURCE_SELECT 16'h0000
`define RESET_GATE_SELECT 16'h0000

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* clc_pkg.sv */
package clc_pkg;

  typedef enum logic [2:0] {
    mode_and_or,
    mode_or_xor,
    mode_and4,
    mode_sr_latch,
    mode_dff_set_reset,
    mode_dff_two_input,
    mode_jk_reset,
    mode_latch_set_reset
  } logic_mode_t;

  typedef struct packed {
    logic cell_enable;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic pin_drive_enable;
    logic output_invert;
    logic_mode_t mode;
    logic [3:0] gate_invert;
    logic [11:0] source_select;
    logic [31:0] gate_enables;
  } cell_config_t;

endpackage

/* clc_input_gates.sv */
`timescale 1ns/100ps
`include "clc_cfg.svh"

module clc_input_gates (
  // Candidate signals, eight per multiplexer
  input wire logic [31:0] source_pool,
  // Configuration
  input wire logic [15:0] source_select,
  input wire logic [31:0] gate_enables,
  input wire logic [3:0] gate_invert,
  // Gate results
  output logic [3:0] gates
);

  logic [3:0] sources;
  logic [7:0] offered;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      localparam logic [1:0] lane_index = 2'(i);
      logic [2:0] sel;
      logic [7:0] lane_enables;
      assign sel = source_select[i*`SOURCE_SELECT_STRIDE +: `SOURCE_SELECT_WIDTH];
      assign sources[i] = source_pool[{lane_index, sel}];
      assign offered[2*i+`TRUE_ENABLE_SLOT] = sources[i];
      assign offered[2*i+`INVERTED_ENABLE_SLOT] = ~sources[i];
      assign lane_enables = gate_enables[i*`GATE_ENABLE_STRIDE +: `GATE_ENABLE_STRIDE];
      assign gates[i] = (|(offered & lane_enables)) ^ gate_invert[i];
    end
  endgenerate

endmodule

/* clc_logic_function.sv */
`timescale 1ns/100ps

module clc_logic_function (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic cell_enable,
  input wire clc_pkg::logic_mode_t mode,
  // Gate results
  input wire logic [3:0] gates,
  // Function result
  output logic func_value
);

  logic stored;
  logic gate_one_prev;
  logic clock_rise;
  logic g1;
  logic g2;
  logic g3;
  logic g4;

  assign g1 = gates[0];
  assign g2 = gates[1];
  assign g3 = gates[2];
  assign g4 = gates[3];
  assign clock_rise = g1 & ~gate_one_prev;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_one_prev <= 1'b0;
    end else begin
      gate_one_prev <= cell_enable & g1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stored <= 1'b0;
    end else if (!cell_enable) begin
      stored <= 1'b0;
    end else begin
      case (mode)
        clc_pkg::mode_sr_latch: begin
          if (g3 | g4) begin
            stored <= 1'b0;
          end else if (g1 | g2) begin
            stored <= 1'b1;
          end
        end
        clc_pkg::mode_dff_set_reset: begin
          if (g3) begin
            stored <= 1'b0;
          end else if (g4) begin
            stored <= 1'b1;
          end else if (clock_rise) begin
            stored <= g2;
          end
        end
        clc_pkg::mode_dff_two_input: begin
          if (g3) begin
            stored <= 1'b0;
          end else if (clock_rise) begin
            stored <= g2 & g4;
          end
        end
        clc_pkg::mode_jk_reset: begin
          if (g3) begin
            stored <= 1'b0;
          end else if (clock_rise) begin
            case ({g2, g4})
              2'h2: stored <= 1'b1;
              2'h1: stored <= 1'b0;
              2'h3: stored <= ~stored;
              default: stored <= stored;
            endcase
          end
        end
        clc_pkg::mode_latch_set_reset: begin
          if (g3) begin
            stored <= 1'b0;
          end else if (g4) begin
            stored <= 1'b1;
          end else if (g1) begin
            stored <= g2;
          end
        end
        default: stored <= 1'b0;
      endcase
    end
  end

  always_comb begin
    case (mode)
      clc_pkg::mode_and_or: func_value = (g1 & g2) | (g3 & g4);
      clc_pkg::mode_or_xor: func_value = (g1 | g2) ^ (g3 | g4);
      clc_pkg::mode_and4: func_value = g1 & g2 & g3 & g4;
      default: func_value = stored;
    endcase
  end

endmodule

/* clc_cell.sv */
// Operation
// - Four gates fed by four muxes drawing on 32 candidate signals.
// - Each mux picks one of its eight candidates by a 3-bit field.
// - Gates OR the enabled true and inverted copies of mux outputs.
// - Cell enable clear forces cell_out and pin_out to zero; pin_oe still follows pin drive enable.
// - Rise interrupt enable pulses interrupt on each output rising edge.
// - Fall interrupt enable pulses interrupt on each output falling edge.
// - Pin drive enable decides whether the result drives the pin.
// - Read-only status bit shows the current output level.
// - Output invert bit inverts the cell output.
// - Mode 000 AND-OR, 001 OR-XOR, 010 four-input AND.
// - Mode 011 SR latch, 100 D flip-flop with set and reset.
// - Mode 101 two-input D with reset, 110 JK, 111 latch.
// - Each gate has its own output invert bit.
// - Separate true and inverted enables per gate and source.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "clc_cfg.svh"

module clc_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Candidate signals
  input wire logic [31:0] source_pool,
  // Cell results
  output logic cell_out,
  output logic pin_out,
  output logic pin_oe,
  output logic irq_pulse
);

  logic [15:0] logic_cell_control_low;
  logic [15:0] logic_cell_control_high;
  logic [15:0] logic_cell_source_select;
  logic [15:0] logic_cell_gate_select_low;
  logic [15:0] logic_cell_gate_select_high;

  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_rvalid;
  logic write_mapped;
  logic [7:0] write_word;
  logic [7:0] read_word;
  logic [15:0] read_value;
  logic read_mapped;

  clc_pkg::cell_config_t cfg;
  logic [3:0] gates;
  logic func_value;
  logic next_cell;

  // Merges a 16-bit register write under byte strobes and writable mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lanes) | (data[15:0] & lanes);
  endfunction

  function automatic logic is_mapped(input logic [7:0] word);
    is_mapped = (word == `OFFSET_CONTROL_LOW) || (word == `OFFSET_CONTROL_HIGH) ||
                (word == `OFFSET_SOURCE_SELECT) || (word == `OFFSET_GATE_SELECT_LOW) ||
                (word == `OFFSET_GATE_SELECT_HIGH);
  endfunction

  // Write channel acceptance, address and data in either order
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign next_aw_held = (aw_held | (s_axi_awvalid & s_axi_awready)) & ~do_write;
  assign next_w_held = (w_held | (s_axi_wvalid & s_axi_wready)) & ~do_write;
  assign write_word = {aw_addr[7:2], 2'h0};
  assign write_mapped = is_mapped(write_word);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      s_axi_awready <= ~next_aw_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      w_held <= next_w_held;
      s_axi_wready <= ~next_w_held;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      logic_cell_control_low <= `RESET_CONTROL_LOW;
      logic_cell_control_high <= `RESET_CONTROL_HIGH;
      logic_cell_source_select <= `RESET_SOURCE_SELECT;
      logic_cell_gate_select_low <= `RESET_GATE_SELECT;
      logic_cell_gate_select_high <= `RESET_GATE_SELECT;
    end else if (do_write) begin
      case (write_word)
        `OFFSET_CONTROL_LOW: logic_cell_control_low <=
            merge(logic_cell_control_low, w_data, w_strb, `MASK_CONTROL_LOW);
        `OFFSET_CONTROL_HIGH: logic_cell_control_high <=
            merge(logic_cell_control_high, w_data, w_strb, `MASK_CONTROL_HIGH);
        `OFFSET_SOURCE_SELECT: logic_cell_source_select <=
            merge(logic_cell_source_select, w_data, w_strb, `MASK_SOURCE_SELECT);
        `OFFSET_GATE_SELECT_LOW: logic_cell_gate_select_low <=
            merge(logic_cell_gate_select_low, w_data, w_strb, `MASK_GATE_SELECT);
        `OFFSET_GATE_SELECT_HIGH: logic_cell_gate_select_high <=
            merge(logic_cell_gate_select_high, w_data, w_strb, `MASK_GATE_SELECT);
        default: logic_cell_control_low <= logic_cell_control_low;
      endcase
    end
  end

  // Read channel, one outstanding read
  assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | (s_axi_arvalid & s_axi_arready);
  assign read_word = {s_axi_araddr[7:2], 2'h0};
  assign read_mapped = is_mapped(read_word);

  always_comb begin
    case (read_word)
      `OFFSET_CONTROL_LOW: begin
        read_value = logic_cell_control_low;
        read_value[`OUTPUT_LEVEL_STATUS_BIT] = cell_out;
      end
      `OFFSET_CONTROL_HIGH: read_value = logic_cell_control_high;
      `OFFSET_SOURCE_SELECT: read_value = logic_cell_source_select;
      `OFFSET_GATE_SELECT_LOW: read_value = logic_cell_gate_select_low;
      `OFFSET_GATE_SELECT_HIGH: read_value = logic_cell_gate_select_high;
      default: read_value = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= {16'h0000, read_value};
        s_axi_rresp <= read_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // Configuration view of the registers
  assign cfg.cell_enable = logic_cell_control_low[`CELL_ENABLE_BIT];
  assign cfg.rise_irq_enable = logic_cell_control_low[`RISE_IRQ_ENABLE_BIT];
  assign cfg.fall_irq_enable = logic_cell_control_low[`FALL_IRQ_ENABLE_BIT];
  assign cfg.pin_drive_enable = logic_cell_control_low[`PIN_DRIVE_ENABLE_BIT];
  assign cfg.output_invert = logic_cell_control_low[`OUTPUT_INVERT_BIT];
  assign cfg.mode = clc_pkg::logic_mode_t'(logic_cell_control_low[`MODE_MSB:`MODE_LSB]);
  assign cfg.gate_invert = logic_cell_control_high[3:0];
  assign cfg.source_select = {logic_cell_source_select[14:12], logic_cell_source_select[10:8],
                              logic_cell_source_select[6:4], logic_cell_source_select[2:0]};
  assign cfg.gate_enables = {logic_cell_gate_select_high, logic_cell_gate_select_low};

  // Muxes and input gates
  clc_input_gates u_gates (
    .source_pool(source_pool),
    .source_select({1'b0, cfg.source_select[11:9], 1'b0, cfg.source_select[8:6],
                    1'b0, cfg.source_select[5:3], 1'b0, cfg.source_select[2:0]}),
    .gate_enables(cfg.gate_enables),
    .gate_invert(cfg.gate_invert),
    .gates(gates)
  );

  clc_logic_function u_function (
    .clk(clk),
    .reset(reset),
    .cell_enable(cfg.cell_enable),
    .mode(cfg.mode),
    .gates(gates),
    .func_value(func_value)
  );

  assign next_cell = cfg.cell_enable & (func_value ^ cfg.output_invert);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cell_out <= 1'b0;
    end else begin
      cell_out <= next_cell;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= next_cell & cfg.pin_drive_enable;
      pin_oe <= cfg.pin_drive_enable;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= (cfg.rise_irq_enable & next_cell & ~cell_out) |
                   (cfg.fall_irq_enable & ~next_cell & cell_out);
    end
  end

endmodule

/* clc_props.sv */
`timescale 1ns/100ps
`include "clc_cfg.svh"

module clc_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Cell
  input wire logic [31:0] source_pool,
  input wire logic cell_out,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic irq_pulse
);
  logic [7:0] aw_addr;
  logic [15:0] w_data;
  logic [15:0] ctrl;
  logic b_seen;

  // Shadow of control low, one cycle behind the register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_addr <= 8'h00;
      w_data <= 16'h0000;
      ctrl <= 16'h0000;
      b_seen <= 1'b0;
    end else begin
      b_seen <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_data <= s_axi_wdata[15:0];
      if (s_axi_bvalid && !b_seen && s_axi_bresp == `RESP_OKAY && aw_addr[7:2] == 6'h00)
        ctrl <= w_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_irq_rise;
    $rose(cell_out) && ctrl[11] |-> irq_pulse;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("no rise pulse");
  property p_irq_fall;
    $fell(cell_out) && ctrl[10] |-> irq_pulse;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("no fall pulse");
  property p_irq_cause;
    irq_pulse |-> $rose(cell_out) && ctrl[11] || $fell(cell_out) && ctrl[10];
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray pulse");
  property p_disabled;
    !ctrl[15] |-> !cell_out && !pin_out;
  endproperty
  a_disabled: assert property (p_disabled) else $error("output while disabled");
  property p_pin_off;
    !ctrl[7] |-> !pin_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven high");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##1 !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("late write answer");
  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_release: assert property (p_b_release) else $error("bvalid held");
  property p_r_release;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_release: assert property (p_r_release) else $error("rvalid held");
endmodule

bind clc_cell clc_props clc_props_inst (.*);

/* clc_source_model.sv */
`timescale 1ns/100ps

module clc_source_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wanted levels and selections
  input wire logic [3:0] levels,
  input wire logic [15:0] select,
  // Candidates
  output logic [31:0] source_pool
);
  logic toggle;

  // Unselected candidates toggle every cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      toggle <= 1'b0;
      source_pool <= 32'h0000_0000;
    end else begin
      toggle <= !toggle;
      for (int k = 0; k < 32; k++) begin
        source_pool[k] <= (3'(k % 8) == select[4 * (k / 8) +: 3]) ? levels[k / 8] : toggle ^ k[0];
      end
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
`include "clc_cfg.svh"

module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, source_pool;
  logic cell_out, pin_out, pin_oe, irq_pulse;
  logic [3:0] levels = 4'h0;
  logic [15:0] select = 16'h0000;
  int miscompares = 0, num_checks = 0;
  int pulses = 0, mark = 0;
  // Control low, gate levels {g4..g1}, expected output
  logic [23:0] rows [34] = '{
    24'h8c8031, 24'h8c8050, 24'h8c80c1, 24'h8c8111, 24'h8c8150, 24'h8c82f1,
    24'h8c8270, 24'h8ca271, 24'h8ca030, 24'h8c8311, 24'h8c8301, 24'h8c8340,
    24'h8c8300, 24'h8c8440, 24'h8c8420, 24'h8c8431, 24'h8c8401, 24'h8c8450,
    24'h8c8481, 24'h8c8540, 24'h8c85a0, 24'h8c85b1, 24'h8c8640, 24'h8c8620,
    24'h8c8631, 24'h8c86a1, 24'h8c86b0, 24'h8c8740, 24'h8c8731, 24'h8c8721,
    24'h8c8710, 24'h8c8781, 24'h0080f0, 24'h800031};

  clc_cell clc_cell_inst (.*);
  clc_source_model clc_source_model_inst (.*);

  always #2.5 clk = ~clk;

  // Counts cycles with the interrupt pulse high
  always @(posedge clk) begin
    if (irq_pulse === 1'b1) pulses <= pulses + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] dt, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, dt};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {16'h0000, e});
    chk(s_axi_rresp, er);
  endtask

  task automatic row(input logic [23:0] w);
    logic e;
    e = w[0];
    wr(`OFFSET_CONTROL_LOW, w[23:8], `RESP_OKAY);
    levels <= w[7:4];
    repeat (5) @(posedge clk);
    chk(cell_out, e);
    chk(pin_out, e & w[15]);
    chk(pin_oe, w[15]);
    rchk(`OFFSET_CONTROL_LOW, w[23:8] | {9'h000, e, 6'h00}, `RESP_OKAY);
  endtask

  task stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      rchk(8'(4 * a), 16'h0000, `RESP_OKAY);
    end
    chk(cell_out, 1'b0);
    wr(`OFFSET_CONTROL_HIGH, 16'hffff, `RESP_OKAY);
    rchk(`OFFSET_CONTROL_HIGH, 16'h000f, `RESP_OKAY);
    wr(`OFFSET_SOURCE_SELECT, 16'hffff, `RESP_OKAY);
    rchk(`OFFSET_SOURCE_SELECT, 16'h7777, `RESP_OKAY);
    wr(`OFFSET_GATE_SELECT_HIGH, 16'hffff, `RESP_OKAY);
    rchk(`OFFSET_GATE_SELECT_HIGH, 16'hffff, `RESP_OKAY);
    wr(`OFFSET_CONTROL_LOW, 16'h7fff, `RESP_OKAY);
    rchk(`OFFSET_CONTROL_LOW, 16'h0ca7, `RESP_OKAY);
    wr(8'h20, 16'hffff, `RESP_SLVERR);
    rchk(8'h20, 16'h0000, `RESP_SLVERR);
    // Gate k follows candidate 8k, true copy
    wr(`OFFSET_CONTROL_HIGH, 16'h0000, `RESP_OKAY);
    wr(`OFFSET_SOURCE_SELECT, 16'h0000, `RESP_OKAY);
    wr(`OFFSET_GATE_SELECT_LOW, 16'h0802, `RESP_OKAY);
    wr(`OFFSET_GATE_SELECT_HIGH, 16'h8020, `RESP_OKAY);
    foreach (rows[i]) row(rows[i]);
    // Other candidates, inverted copies, then gate inversion
    select <= 16'h7531;
    wr(`OFFSET_SOURCE_SELECT, 16'h7531, `RESP_OKAY);
    wr(`OFFSET_GATE_SELECT_LOW, 16'h0401, `RESP_OKAY);
    wr(`OFFSET_GATE_SELECT_HIGH, 16'h4010, `RESP_OKAY);
    row(24'h8c80c1);
    row(24'h8c8050);
    wr(`OFFSET_CONTROL_HIGH, 16'h000f, `RESP_OKAY);
    row(24'h8c8031);
    wr(`OFFSET_CONTROL_HIGH, 16'h0001, `RESP_OKAY);
    row(24'h8c80e0);
    row(24'h8c8011);
    // Edge interrupts, one enable at a time
    wr(`OFFSET_CONTROL_LOW, 16'h8880, `RESP_OKAY);
    mark = pulses;
    levels <= 4'he;
    repeat (5) @(posedge clk);
    chk(pulses - mark, 0);
    levels <= 4'h1;
    repeat (5) @(posedge clk);
    chk(pulses - mark, 1);
    wr(`OFFSET_CONTROL_LOW, 16'h8480, `RESP_OKAY);
    levels <= 4'he;
    repeat (5) @(posedge clk);
    chk(pulses - mark, 2);
    levels <= 4'h1;
    repeat (5) @(posedge clk);
    chk(pulses - mark, 2);
    chk(cell_out, 1'b1);
    // Reset in mid-run with the cell high
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk(cell_out, 1'b0);
    chk(pin_oe, 1'b0);
    rchk(`OFFSET_CONTROL_LOW, 16'h0000, `RESP_OKAY);
    rchk(`OFFSET_CONTROL_HIGH, 16'h0000, `RESP_OKAY);
    stop_test;
  end
endmodule
